// ### inc/ptt_pkg.sv
// Constants shared by the periodic tick timer block and its bench.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Function
// - Each timer has clock select, prescaler, 16-bit up counter, modulo and control.
// - Modulo and control are read/write; the counter reads only, writes ignored.
// - When enabled, count to modulo, flag rollover, wrap to zero, keep counting.
// - Wrap and rollover happen on the count clock after counter equals modulo.
// - Modulo zero keeps counter at zero with rollover on every count clock.
// - Every wrap at modulo sets the flag; interrupt requested only while enable bit set.
// - Software can clear the rollover flag to acknowledge the event.
// - Count clock is source clock divided by powers of two, 1 to 32768.
// - Clock select picks bus clock or one of three alternate clock inputs.
// - The count-run bit starts and stops a non-slaved timer.
// - Timers one and two may be slaved to the count-run bit of timer zero.
// - A slaved timer ignores its own count-run bit.
package ptt_pkg;

    // Sizes of the block.
    localparam int unsigned PTT_NUM_INST   = 3;
    localparam int unsigned PTT_CNT_W      = 16;
    localparam int unsigned PTT_PSEL_W     = 4;
    localparam int unsigned PTT_PDIV_W     = 15;
    localparam int unsigned PTT_CSEL_W     = 2;
    localparam int unsigned PTT_ALT_CLKS   = 3;
    localparam int unsigned PTT_ADDR_W     = 8;

    // Register map: each timer owns a window of sixteen bytes.
    localparam logic [7:0]  PTT_INST_STRIDE = 8'h10;
    localparam logic [3:0]  PTT_OFS_CTRL    = 4'h0;
    localparam logic [3:0]  PTT_OFS_MOD     = 4'h4;
    localparam logic [3:0]  PTT_OFS_CNT     = 4'h8;
    localparam logic [7:0]  PTT_ADR_STATUS  = 8'h30;
    localparam logic [7:0]  PTT_ADR_MASK    = 8'h34;

    // Control register field positions.
    localparam int unsigned PTT_CTRL_RUN    = 0;
    localparam int unsigned PTT_CTRL_SLAVE  = 1;
    localparam int unsigned PTT_CTRL_FLAG   = 2;
    localparam int unsigned PTT_CTRL_PSEL   = 4;
    localparam int unsigned PTT_CTRL_CSEL   = 8;

    // Reset values.
    localparam logic [15:0] PTT_MOD_RST     = 16'h0000;
    localparam logic [15:0] PTT_CNT_RST     = 16'h0000;
    localparam logic [3:0]  PTT_PSEL_RST    = 4'h0;
    localparam logic [31:0] PTT_RD_ZERO     = 32'h0000_0000;

    // Counter clock sources.
    typedef enum logic [1:0] {
        PTT_SRC_BUS  = 2'b00,
        PTT_SRC_ALT1 = 2'b01,
        PTT_SRC_ALT2 = 2'b10,
        PTT_SRC_ALT3 = 2'b11
    } ptt_src_t;

    // Bus slave states.
    typedef enum logic [0:0] {
        PTT_BUS_IDLE = 1'b0,
        PTT_BUS_ACK  = 1'b1
    } ptt_bus_t;

endpackage

// ### rtl/ptt_periodic_timer.sv
// Periodic tick timer block with several timer channels behind a Wishbone slave.
// Assumes all inputs synchronous to sys_clk and a classic single-cycle Wishbone master.
// Software is assumed to stop a timer before changing its clock source.
`timescale 1ns/1ps

module ptt_periodic_timer
    import ptt_pkg::*;
#(
    parameter int unsigned NUM_INST = PTT_NUM_INST
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [PTT_ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic [PTT_ALT_CLKS-1:0] altClk,
    output logic      [NUM_INST-1:0]     rollPulse,
    output logic                         irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    // All state clears on rst: timers stopped, divide by one,
    // bus clock source, modulo zero, interrupts masked.
    logic [NUM_INST-1:0]   runBit;
    logic [NUM_INST-1:0]   slaveBit;
    logic [NUM_INST-1:0]   rollFlag;
    logic [NUM_INST-1:0]   irqMask;
    logic [PTT_PSEL_W-1:0] prescSel   [NUM_INST];
    logic [PTT_CSEL_W-1:0] clkSel     [NUM_INST];
    logic [PTT_CNT_W-1:0]  modulo     [NUM_INST];
    logic [PTT_CNT_W-1:0]  count      [NUM_INST];
    // The run bit that really gates each core.
    logic [NUM_INST-1:0]   effRun;
    logic [NUM_INST-1:0]   srcTick;
    logic [NUM_INST-1:0]   rollTick;
    logic [PTT_ALT_CLKS-1:0] altPrev;
    logic [PTT_ALT_CLKS-1:0] altRise;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Every request is answered after one wait state, so
    // a master waiting for ack cannot hang: unmapped reads
    // return zero and unmapped writes are dropped.
    // A timer offset that is not word aligned reads zero.
    ptt_bus_t              busState;
    logic                  busReq;
    logic                  wrStrobe;
    logic [3:0]            instSel;
    logic [3:0]            regOfs;
    logic                  instHit;
    logic [31:0]           next_rdData;
    logic [31:0]           wrMerged;
    logic [31:0]           ctrlRd     [NUM_INST];

    // A request is served once; ack drops in the cycle after it was given.
    // Ignoring cyc and stb in the ack cycle keeps a late
    // strobe drop from starting a phantom second transfer.
    assign busReq   = wb_cyc_i && wb_stb_i && (busState == PTT_BUS_IDLE);
    assign wrStrobe = busReq && wb_we_i;
    assign instSel  = wb_adr_i[7:4];
    assign regOfs   = wb_adr_i[3:0];
    assign instHit  = (32'(instSel) < NUM_INST);

    // Byte lanes outside sel keep zero; registers narrower than a word sit low.
    // Trade-off: one merge serves every register, but a
    // partial write zeroes the unselected lanes.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wrMerged[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : 8'h00;
        end
    end

    // Bus handshake: one wait state, ack is a one-cycle pulse.
    // Writes land at the edge that takes the request, so a
    // read right after a write already sees the new value.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busState <= PTT_BUS_IDLE;
        end else begin
            case (busState)
                PTT_BUS_IDLE: begin
                    if (busReq) begin
                        busState <= PTT_BUS_ACK;
                    end
                end
                PTT_BUS_ACK: begin
                    busState <= PTT_BUS_IDLE;
                end
                default: begin
                    busState <= PTT_BUS_IDLE;
                end
            endcase
        end
    end

    // Ack comes straight from the state flop, free of decode glitches.
    assign wb_ack_o = (busState == PTT_BUS_ACK);

    ////////////////////////////////////////////////////////////////////////////
    // Clock source selection.

    // Alternate clocks are synchronous levels; a rising edge gives one source tick.
    // No synchroniser is fitted: an asynchronous source must
    // be synchronised outside, or a metastable sample may
    // give a false tick. A source above half of sys_clk
    // loses edges.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            altPrev <= '0;
        end else begin
            altPrev <= altClk;
        end
    end

    // History resets to the idle low level, so no false edge follows reset.
    assign altRise = altClk & ~altPrev;

    ////////////////////////////////////////////////////////////////////////////
    // Per-timer channels.
    // Timing with the bus clock and divide by one: a run bit
    // written at edge E gives count one at edge E+1. At
    // count equal to modulo, the next count tick wraps to
    // zero and sets the flag; pulse and flag appear
    // together, irq one cycle later. With divider n, count
    // ticks fall every 2**n source ticks, the first 2**n
    // ticks after run, as the divider restarts when stopped.

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INST; gi++) begin : g_inst

            // Only timers past the first may follow timer zero's run bit.
            // A slaved timer keeps its own run bit stored, so
            // leaving slave mode restores its own control.
            // Slaving joins run control only; divider, source
            // and modulo stay per timer.
            if (gi == 0) begin : g_master
                assign effRun[gi] = runBit[gi];
            end else begin : g_follower
                assign effRun[gi] = slaveBit[gi] ? runBit[0] : runBit[gi];
            end

            // Bus clock ticks every cycle; alternate sources tick on their rising edges.
            // A source switch while running does not restart the
            // divider, so one count period may come out short or long.
            always_comb begin
                case (ptt_src_t'(clkSel[gi]))
                    PTT_SRC_BUS:  srcTick[gi] = 1'b1;
                    PTT_SRC_ALT1: srcTick[gi] = altRise[0];
                    PTT_SRC_ALT2: srcTick[gi] = altRise[1];
                    PTT_SRC_ALT3: srcTick[gi] = altRise[2];
                    // Every code is named; the default keeps the case total.
                    default:      srcTick[gi] = 1'b0;
                endcase
            end

            // The core owns divider and counter; this level only
            // decides when it counts and where ticks come from.
            ptt_timer_core #(
                .CNT_W    (PTT_CNT_W),
                .PDIV_W   (PTT_PDIV_W)
            ) u_core (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .run      (effRun[gi]),
                .srcTick  (srcTick[gi]),
                .prescSel (prescSel[gi]),
                .modulo   (modulo[gi]),
                .count    (count[gi]),
                .rollTick (rollTick[gi])
            );

            // Read view of the control register; the slave bit of timer zero reads zero.
            // Unlisted fields read zero.
            always_comb begin
                ctrlRd[gi] = PTT_RD_ZERO;
                ctrlRd[gi][PTT_CTRL_RUN] = runBit[gi];
                ctrlRd[gi][PTT_CTRL_SLAVE] = (gi != 0) ? slaveBit[gi] : 1'b0;
                ctrlRd[gi][PTT_CTRL_FLAG] = rollFlag[gi];
                ctrlRd[gi][PTT_CTRL_PSEL +: PTT_PSEL_W] = prescSel[gi];
                ctrlRd[gi][PTT_CTRL_CSEL +: PTT_CSEL_W] = clkSel[gi];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Control and modulo registers.

    // Clock select may change at any time; software stops the timer first, since a
    // switch while running can give one short or long count period.
    // A write to the counter offset matches neither branch
    // and is dropped, so the counter is read only.
    // Timer zero has no slave setting; its bit stays zero.
    // A modulo lowered below a running count lets the count
    // run to its top value and wrap with no rollover event.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            runBit   <= '0;
            slaveBit <= '0;
            for (int i = 0; i < NUM_INST; i++) begin
                prescSel[i] <= PTT_PSEL_RST;
                clkSel[i]   <= PTT_SRC_BUS;
                modulo[i]   <= PTT_MOD_RST;
            end
        end else if (wrStrobe && instHit) begin
            for (int i = 0; i < NUM_INST; i++) begin
                if (32'(instSel) == i) begin
                    if (regOfs == PTT_OFS_CTRL) begin
                        runBit[i]   <= wrMerged[PTT_CTRL_RUN];
                        slaveBit[i] <= (i != 0) && wrMerged[PTT_CTRL_SLAVE];
                        prescSel[i] <= wrMerged[PTT_CTRL_PSEL +: PTT_PSEL_W];
                        clkSel[i]   <= wrMerged[PTT_CTRL_CSEL +: PTT_CSEL_W];
                    end else if (regOfs == PTT_OFS_MOD) begin
                        modulo[i]   <= wrMerged[PTT_CNT_W-1:0];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rollover flags and interrupt.

    // Each flag shows in its control word and in status.
    logic [NUM_INST-1:0] flagClr;

    // A one written to the flag in the control word or in the status word clears it.
    always_comb begin
        flagClr = '0;
        if (wrStrobe) begin
            if (wb_adr_i == PTT_ADR_STATUS) begin
                flagClr = wrMerged[NUM_INST-1:0];
            end
            for (int i = 0; i < NUM_INST; i++) begin
                if (instHit && (32'(instSel) == i) && (regOfs == PTT_OFS_CTRL)) begin
                    flagClr[i] = wrMerged[PTT_CTRL_FLAG];
                end
            end
        end
    end

    // A wrap in the same cycle as the clear wins, so no event is lost.
    // Writing the control word back as read clears a set
    // flag; write a zero there to keep it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rollFlag <= '0;
        end else begin
            rollFlag <= (rollFlag & ~flagClr) | rollTick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt enables and output.

    // Mask register holds the rollover interrupt enables.
    // The mask gates only irq, never the flag, so polling
    // works with every enable off.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqMask <= '0;
        end else if (wrStrobe && (wb_adr_i == PTT_ADR_MASK)) begin
            irqMask <= wrMerged[NUM_INST-1:0];
        end
    end

    // Level interrupt, held while any enabled flag is set.
    // Registered to stay glitch free, so irq lags the flags
    // by one cycle both ways; masking a set flag drops irq
    // a cycle later without clearing the flag.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(rollFlag & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wrap pulses.

    // Wrap pulses are registered so they line up with the flag setting.
    // Software reading status then sees the flag set.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rollPulse <= '0;
        end else begin
            rollPulse <= rollTick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Counter reads live state; unmapped addresses read zero.
    // Status and mask decode the full address; a timer
    // window uses the upper nibble for the timer and the
    // lower for the register. A counter read returns the
    // value at the taking edge; a running count moves on.
    always_comb begin
        next_rdData = PTT_RD_ZERO;
        if (wb_adr_i == PTT_ADR_STATUS) begin
            next_rdData[NUM_INST-1:0] = rollFlag;
        end else if (wb_adr_i == PTT_ADR_MASK) begin
            next_rdData[NUM_INST-1:0] = irqMask;
        end else begin
            for (int i = 0; i < NUM_INST; i++) begin
                if (instHit && (32'(instSel) == i)) begin
                    case (regOfs)
                        PTT_OFS_CTRL: next_rdData = ctrlRd[i];
                        PTT_OFS_MOD:  next_rdData[PTT_CNT_W-1:0] = modulo[i];
                        PTT_OFS_CNT:  next_rdData[PTT_CNT_W-1:0] = count[i];
                        default:      next_rdData = PTT_RD_ZERO;
                    endcase
                end
            end
        end
    end

    // Read data is captured with the request and stands through the ack cycle.
    // Holding it until the next read saves a clear path and
    // lets a slow master sample it late.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_dat_o <= PTT_RD_ZERO;
        end else if (busReq && !wb_we_i) begin
            wb_dat_o <= next_rdData;
        end
    end

    // Limits for integrators: alternate sources are sampled
    // levels, one count tick per source edge at most; the
    // counter is sixteen bits and the divider fifteen, so
    // the longest period is 2**31 source ticks. There is no
    // one-shot mode: a timer keeps wrapping until stopped.

endmodule

// ### rtl/ptt_timer_core.sv
// One timer channel: prescaler and 16-bit up counter with modulo wrap.
// Assumes a one-cycle source tick per source clock edge, already selected.
`timescale 1ns/1ps

module ptt_timer_core
    import ptt_pkg::*;
#(
    parameter int unsigned CNT_W  = PTT_CNT_W,
    parameter int unsigned PDIV_W = PTT_PDIV_W
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  run,
    input  wire logic                  srcTick,
    input  wire logic [PTT_PSEL_W-1:0] prescSel,
    input  wire logic [CNT_W-1:0]      modulo,
    output logic      [CNT_W-1:0]      count,
    output logic                       rollTick
);

    logic [PDIV_W-1:0] divCount;
    logic [PDIV_W:0]   divMask;
    logic              countTick;

    // A count tick falls on the source tick that completes 2**prescSel source ticks.
    assign divMask   = ({{PDIV_W{1'b0}}, 1'b1} << prescSel) - {{PDIV_W{1'b0}}, 1'b1};
    assign countTick = run && srcTick && ((divCount & divMask[PDIV_W-1:0]) == divMask[PDIV_W-1:0]);

    // The divider restarts while stopped so a new run begins with a full period.
    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            divCount <= '0;
        end else if (srcTick) begin
            divCount <= divCount + {{(PDIV_W-1){1'b0}}, 1'b1};
        end
    end

    // Equal to modulo waits one more count clock, then wraps; modulo zero stays at zero.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= PTT_CNT_RST;
        end else if (countTick) begin
            if (count == modulo) begin
                count <= '0;
            end else begin
                count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // One-cycle pulse on each wrap at modulo.
    assign rollTick = countTick && (count == modulo);

endmodule

// ### sim/ptt_periodic_timer_assertions.sv
// Checker for the periodic tick timer top: bus answer timing, read limits, interrupt causes.
// Sees only top-level ports; attached by the bind after the module.
`timescale 1ns/1ps

module ptt_periodic_timer_assertions
    import ptt_pkg::*;
#(
    parameter int unsigned NUM_INST = PTT_NUM_INST
) (
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [PTT_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic [NUM_INST-1:0]   rollPulse,
    input wire logic                  irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // A request is taken only while no answer shows, so a held strobe is not taken twice.
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_read(a);
        s_take ##0 (!wb_we_i && wb_adr_i == a);
    endsequence

    ////////////////////////////////////////////////////////////
    // Handshake, reset state, read-back limits and interrupt causes.
    a_ack_latency: assert property (s_take |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    a_reset_clear: assert property ($fell(rst) |-> !wb_ack_o && !irq && rollPulse == '0)
        else $error("outputs busy after reset");
    a_cnt_width: assert property (s_read(8'h08) |=> wb_dat_o[31:16] == 16'h0000)
        else $error("counter wider than 16 bits");
    a_slave_zero: assert property (s_read(8'h00) |=> !wb_dat_o[PTT_CTRL_SLAVE])
        else $error("timer zero shows slave bit");
    a_hole_zero: assert property (s_read(8'h3C) |=> wb_dat_o == PTT_RD_ZERO)
        else $error("unmapped read not zero");
    a_irq_cause: assert property ($rose(irq) |-> $past(rollPulse != '0) || $past(wb_ack_o))
        else $error("irq rose without event");
    a_irq_clear: assert property ($fell(irq) && !$past(rst) |-> $past(wb_ack_o))
        else $error("irq fell without write");
endmodule

bind ptt_periodic_timer ptt_periodic_timer_assertions #(.NUM_INST(NUM_INST)) u_chk (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rollPulse(rollPulse),
    .irq      (irq)
);

// ### sim/test_ptt_periodic_timer.sv
// Self-checking bench for the periodic tick timer: registers, prescaler, wrap, irq, clocks, slaving.
// Drives all top inputs itself; the checker joins through its own bind.
`timescale 1ns/1ps

module test_ptt_periodic_timer
    import ptt_pkg::*;
;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] RUN = 32'h0000_0001;
    logic        sys_clk     = 1'b0;
    logic        rst         = 1'b1;
    logic        wbCyc       = 1'b0;
    logic        wbStb       = 1'b0;
    logic        wbWe        = 1'b0;
    logic [7:0]  wbAdr       = 8'h00;
    logic [31:0] wbDat       = PTT_RD_ZERO;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic [2:0]  altClk      = 3'h0;
    logic [2:0]  rollPulse;
    logic        irq;
    logic [63:0] expQ[$];
    logic [63:0] monE;
    int          seed        = 55;
    int          mismatches  = 0;
    int          totalChecks = 0;

    ptt_periodic_timer dut (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .wb_cyc_i (wbCyc),
        .wb_stb_i (wbStb),
        .wb_we_i  (wbWe),
        .wb_adr_i (wbAdr),
        .wb_sel_i (4'hF),
        .wb_dat_i (wbDat),
        .wb_dat_o (wbDatR),
        .wb_ack_o (wbAck),
        .altClk   (altClk),
        .rollPulse(rollPulse),
        .irq      (irq)
    );

    // Free-running 50 MHz clock.
    always #10 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One classic cycle; the idle edge first keeps strobe low between transfers.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= we;
        wbAdr <= a;
        wbDat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (wbAck !== 1'b1) mismatches++;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // The expectation is queued before the cycle so the monitor always finds it.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back({m, e});
        bus(1'b0, a, PTT_RD_ZERO);
    endtask

    task automatic waitRoll(input int i, output int k);
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rollPulse[i] !== 1'b1 && k < 40000);
    endtask

    task automatic cnt(input int i, input int n, output int p);
        p = 0;
        repeat (n) begin
            @(posedge sys_clk);
            p += (rollPulse[i] === 1'b1);
        end
    endtask

    // Read answers are matched against the oldest queued note at the ack edge.
    always @(posedge sys_clk) begin
        if (wbAck === 1'b1 && !wbWe && expQ.size() > 0) begin
            monE = expQ.pop_front();
            chk(wbDatR & monE[63:32], monE[31:0]);
        end
    end

    // Watchdog sized well above the longest prescaler sweep.
    initial begin
        #(20 * 85000);
        mismatches++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        int k;
        int p;
        int m;
        int e;
        logic [31:0] v;
        logic [2:0] r;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd(8'(a * 4), PTT_RD_ZERO, ALL);
        $display("test reset done");
        v = $random(seed);
        wr(8'h04, v);
        rd(8'h04, {16'h0000, v[15:0]}, ALL);
        wr(8'h08, ALL);
        rd(8'h08, PTT_RD_ZERO, ALL);
        wr(8'h00, 32'h0000_0002);
        rd(8'h00, PTT_RD_ZERO, ALL);
        wr(8'h04, PTT_RD_ZERO);
        $display("test access done");
        // Modulo zero rolls on every count clock, so the first event time is the divider itself.
        wr(8'h34, RUN);
        for (int n = 0; n < 16; n++) begin
            wr(8'h00, (32'(n) << 4) | RUN);
            waitRoll(0, k);
            chk(32'(k), RUN << n);
            @(posedge sys_clk);
            chk(32'(irq), RUN);
            rd(8'h08, PTT_RD_ZERO, ALL);
            wr(8'h00, PTT_RD_ZERO);
            wr(8'h30, RUN);
            repeat (2) @(posedge sys_clk);
            chk(32'(irq), PTT_RD_ZERO);
        end
        $display("test prescaler done");
        m = 2 + ($random(seed) & 7);
        wr(8'h14, 32'(m));
        wr(8'h10, RUN);
        waitRoll(1, k);
        waitRoll(1, k);
        chk(32'(k), 32'(m + 1));
        chk(32'(irq), PTT_RD_ZERO);
        wr(8'h10, PTT_RD_ZERO);
        rd(8'h30, 32'h0000_0002, 32'h0000_0002);
        wr(8'h10, 32'h0000_0004);
        rd(8'h30, PTT_RD_ZERO, 32'h0000_0002);
        $display("test wrap done");
        // All alternate lines toggle; only the selected one may produce count ticks.
        // Timer two starts at zero; timer one stopped mid-period and would first run to its top.
        wr(8'h24, PTT_RD_ZERO);
        for (int c = 1; c < 4; c++) begin
            wr(8'h20, 32'(c) << 8);
            wr(8'h20, (32'(c) << 8) | RUN);
            e = 0;
            p = 0;
            for (int i = 0; i < 48; i++) begin
                @(posedge sys_clk);
                p += (rollPulse[2] === 1'b1);
                r = (i < 40) ? 3'($random(seed)) : 3'h0;
                e += (r[c-1] && !altClk[c-1]);
                altClk <= r;
            end
            chk(32'(p), 32'(e));
            wr(8'h20, 32'(c) << 8);
        end
        $display("test clocks done");
        wr(8'h20, 32'h0000_0003);
        cnt(2, 10, p);
        chk(32'(p), PTT_RD_ZERO);
        wr(8'h00, RUN);
        cnt(2, 10, p);
        chk(32'(p), 32'h0000_000A);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        cnt(2, 10, p);
        chk(32'(p), PTT_RD_ZERO);
        chk(32'(irq), PTT_RD_ZERO);
        $display("test slave done");
        wrap_up();
    end
endmodule
